// ===== tsap_pkg.sv
package tsap_pkg;
    localparam logic [11:0] TSAP_OFF_STATE   = 12'h020;
    localparam logic [11:0] TSAP_OFF_COUNT   = 12'h024;
    localparam logic [11:0] TSAP_OFF_ACTION  = 12'h028;
    localparam logic [11:0] TSAP_OFF_TXNID   = 12'h02c;
    localparam logic [11:0] TSAP_OFF_RD_ADDR = 12'h040;
    localparam logic [11:0] TSAP_OFF_RD_DATA = 12'h044;
    localparam logic [11:0] TSAP_OFF_WR_ADDR = 12'h048;
    localparam logic [11:0] TSAP_OFF_WR_DATA = 12'h04c;
    localparam int          TSAP_WRAP_BIT    = 31;
    localparam int          TSAP_FINAL_BIT   = 31;
    localparam logic [31:0] TSAP_RST_WORD    = 32'h0000_0000;

    // apb request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tsap_apb_req_t;

    // capture-side write port into the trace memory
    typedef struct packed {
        logic        we;
        logic [7:0]  header;
        logic [127:0] payload;
    } tsap_cap_wr_t;
endpackage

// ===== tsap_top.sv
`timescale 1ns/10ps
`default_nettype none
module tsap_top
    import tsap_pkg::*;
#(
    parameter int ADDR_W   = 8,
    parameter int PAY_W    = 64,
    parameter int STATES_N = 5,
    parameter int ID_W     = 8,
    parameter bit ID_OPT   = 1'b1
) (
    input  wire logic           clk_in,
    input  wire logic           rst_in,
    input  wire tsap_apb_req_t  apb_in,
    output logic [31:0]         prdata_out,
    output logic                pready_out,
    output logic                pslverr_out,
    output logic                run_out,
    input  wire logic [STATES_N-1:0] trig_state_in,
    input  wire logic           final_state_in,
    input  wire logic [31:0]    counter_in,
    input  wire logic [7:0]     action_in,
    input  wire logic           id_match_in,
    input  wire logic [ID_W-1:0] txn_id_in,
    input  wire tsap_cap_wr_t   cap_in
);
    localparam int PIECES = PAY_W / 32;
    localparam int IDX_W  = $clog2(PIECES + 1);
    localparam int HOLD_W = 8 + PAY_W;
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(PIECES);

    logic [HOLD_W-1:0] mem_q [0:(1<<ADDR_W)-1];
    logic [31:0]       ctrl_q;
    logic [STATES_N-1:0] state_q;
    logic              final_q;
    logic [31:0]       count_snap_q;
    logic [7:0]        act_snap_q;
    logic [ID_W-1:0]   txn_id_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic              wrap_q;
    logic [HOLD_W-1:0] rd_hold_q;
    logic [HOLD_W-1:0] wr_hold_q;
    logic [IDX_W-1:0]  rd_idx_q;
    logic [IDX_W-1:0]  wr_idx_q;
    logic [31:0]       rdata_d;

    // single access phase, never stalls
    logic acc;
    logic wr;
    logic rd;
    assign acc = apb_in.psel && apb_in.penable;
    assign wr  = acc && apb_in.pwrite;
    assign rd  = acc && !apb_in.pwrite;
    assign pready_out  = 1'b1;
    assign pslverr_out = 1'b0;
    assign run_out     = ctrl_q[0];

    logic rd_addr_wr;
    logic rd_data_rd;
    logic wr_addr_wr;
    logic wr_data_wr;
    logic rd_last;
    logic wr_last;
    logic cap_we;
    assign rd_addr_wr = wr && apb_in.paddr == TSAP_OFF_RD_ADDR;
    assign rd_data_rd = rd && apb_in.paddr == TSAP_OFF_RD_DATA;
    assign wr_addr_wr = wr && apb_in.paddr == TSAP_OFF_WR_ADDR;
    assign wr_data_wr = wr && apb_in.paddr == TSAP_OFF_WR_DATA;
    assign rd_last    = rd_data_rd && rd_idx_q == IDX_LAST;
    assign wr_last    = wr_data_wr && wr_idx_q == IDX_LAST;
    // capture only writes while enabled
    assign cap_we     = cap_in.we && ctrl_q[0];

    // run control register at offset zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= TSAP_RST_WORD;
        end else if (wr && apb_in.paddr == 12'h000) begin
            ctrl_q <= {31'h0, apb_in.pwdata[0]};
        end
    end

    // trigger state tracking, frozen once final
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= STATES_N'(1);
            final_q <= 1'b0;
        end else if (!ctrl_q[0]) begin
            final_q <= 1'b0;
            state_q <= trig_state_in;
        end else if (!final_q) begin
            state_q <= trig_state_in;
            final_q <= final_state_in;
        end
    end

    // snapshots taken on the state register read
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_snap_q <= TSAP_RST_WORD;
            act_snap_q   <= 8'h00;
        end else if (rd && apb_in.paddr == TSAP_OFF_STATE) begin
            count_snap_q <= counter_in;
            act_snap_q   <= action_in;
        end
    end

    // id capture, last match wins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            txn_id_q <= '0;
        end else if (ID_OPT && ctrl_q[0] && id_match_in) begin
            txn_id_q <= txn_id_in;
        end
    end

    // read path: load on address write, refill after last piece
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_addr_q <= '0;
            rd_hold_q <= '0;
            rd_idx_q  <= '0;
        end else if (rd_addr_wr) begin
            rd_hold_q <= mem_q[apb_in.pwdata[ADDR_W-1:0]];
            rd_addr_q <= apb_in.pwdata[ADDR_W-1:0] + 1'b1;
            rd_idx_q  <= '0;
        end else if (rd_last) begin
            rd_hold_q <= mem_q[rd_addr_q];
            rd_addr_q <= rd_addr_q + 1'b1;
            rd_idx_q  <= '0;
        end else if (rd_data_rd) begin
            rd_idx_q <= rd_idx_q + 1'b1;
        end
    end

    // write address: host and capture share the pointer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_addr_q <= '0;
            wrap_q    <= 1'b0;
        end else if (wr_addr_wr) begin
            wr_addr_q <= apb_in.pwdata[ADDR_W-1:0];
            wrap_q    <= apb_in.pwdata[TSAP_WRAP_BIT];
        end else if (cap_we) begin
            wr_addr_q <= wr_addr_q + 1'b1;
            if (&wr_addr_q) begin
                wrap_q <= 1'b1;
            end
        end else if (wr_last) begin
            wr_addr_q <= wr_addr_q + 1'b1;
        end
    end

    // write holding register fill, header first
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_hold_q <= '0;
            wr_idx_q  <= '0;
        end else if (wr_addr_wr) begin
            wr_idx_q <= '0;
        end else if (wr_data_wr) begin
            if (wr_idx_q == '0) begin
                wr_hold_q[HOLD_W-1 -: 8] <= apb_in.pwdata[7:0];
            end else begin
                wr_hold_q[32*(wr_idx_q-1) +: 32] <= apb_in.pwdata;
            end
            wr_idx_q <= wr_last ? '0 : wr_idx_q + 1'b1;
        end
    end

    // trace memory: capture has priority, host must be idle while running
    always_ff @(posedge clk_in) begin
        if (cap_we) begin
            mem_q[wr_addr_q] <= {cap_in.header, cap_in.payload[PAY_W-1:0]};
        end else if (wr_last) begin
            mem_q[wr_addr_q] <= {wr_hold_q[HOLD_W-1 -: 8], apb_in.pwdata,
                                 wr_hold_q[PAY_W-33:0]};
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = 32'h0;
        unique case (apb_in.paddr)
            TSAP_OFF_STATE: begin
                rdata_d[TSAP_FINAL_BIT] = final_q;
                if (ctrl_q[0]) begin
                    rdata_d[STATES_N-1:0] = state_q;
                end
            end
            TSAP_OFF_COUNT:   rdata_d = count_snap_q;
            TSAP_OFF_ACTION:  rdata_d[7:0] = act_snap_q;
            TSAP_OFF_TXNID:   rdata_d[ID_W-1:0] = txn_id_q;
            TSAP_OFF_RD_ADDR: rdata_d[ADDR_W-1:0] = rd_addr_q;
            TSAP_OFF_RD_DATA: begin
                if (rd_idx_q == '0) begin
                    rdata_d[7:0] = rd_hold_q[HOLD_W-1 -: 8];
                end else begin
                    rdata_d = rd_hold_q[32*(rd_idx_q-1) +: 32];
                end
            end
            TSAP_OFF_WR_ADDR: begin
                rdata_d[ADDR_W-1:0]    = wr_addr_q;
                rdata_d[TSAP_WRAP_BIT] = wrap_q;
            end
            12'h000:          rdata_d = ctrl_q;
            default:          rdata_d = 32'h0;
        endcase
    end
    // combinational read data in the access phase
    assign prdata_out = rd ? rdata_d : 32'h0;
    // host is trusted to keep out of the memory registers while running
endmodule
`default_nettype wire

// ===== tsap_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tsap_chk
    import tsap_pkg::*;
#(
    parameter int ADDR_W   = 8,
    parameter int STATES_N = 5
) (
    input wire logic          clk_in,
    input wire logic          rst_in,
    input wire tsap_apb_req_t apb_in,
    input wire logic [31:0]   prdata_out,
    input wire logic          run_out,
    input wire logic [31:0]   counter_in,
    input wire logic [7:0]    action_in
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // access-phase decode per offset; setup cycles never count
    function automatic logic hit(logic w, logic [11:0] a);
        return apb_in.psel && apb_in.penable && apb_in.pwrite == w
            && apb_in.paddr == a;
    endfunction
    a_idle_zero: assert property (!(apb_in.psel && apb_in.penable)
        |-> prdata_out == 32'h0) else $error("read data not idle");
    a_state_off: assert property (hit(0, TSAP_OFF_STATE) && !run_out
        |-> prdata_out == 32'h0) else $error("state not zero when off");
    a_state_onehot: assert property (hit(0, TSAP_OFF_STATE) && run_out
        |-> $onehot(prdata_out[STATES_N-1:0])) else $error("state not one-hot");
    a_count_snap: assert property (hit(0, TSAP_OFF_STATE) ##3
        hit(0, TSAP_OFF_COUNT) |-> prdata_out == $past(counter_in, 3))
        else $error("counter snapshot wrong");
    a_action_snap: assert property (hit(0, TSAP_OFF_STATE) ##3
        hit(0, TSAP_OFF_ACTION) |-> prdata_out == {24'h0, $past(action_in, 3)})
        else $error("action snapshot wrong");
    a_rd_addr_step: assert property (hit(1, TSAP_OFF_RD_ADDR) ##3
        hit(0, TSAP_OFF_RD_ADDR) |-> prdata_out[ADDR_W-1:0]
        == $past(apb_in.pwdata[ADDR_W-1:0], 3) + 1'b1)
        else $error("read address did not step");
    a_header_first: assert property (hit(1, TSAP_OFF_RD_ADDR) ##3
        hit(0, TSAP_OFF_RD_DATA) |-> prdata_out[31:8] == 24'h0)
        else $error("header not zero-extended");
    a_run_bit: assert property (hit(1, 12'h000) |=>
        run_out == $past(apb_in.pwdata[0])) else $error("run bit wrong");
endmodule
bind tsap_top tsap_chk #(.ADDR_W(ADDR_W), .STATES_N(STATES_N)) i_chk (
    .clk_in(clk_in), .rst_in(rst_in), .apb_in(apb_in), .run_out(run_out),
    .prdata_out(prdata_out), .counter_in(counter_in), .action_in(action_in));
`default_nettype wire

// ===== tsap_host.sv
`timescale 1ns/10ps
`default_nettype none
module tsap_host
    import tsap_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        pready_in,
    output var tsap_apb_req_t req_out
);
    initial req_out = '0;
    // one transfer, held until ready is seen at an access edge
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk_in);
        req_out <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        req_out.penable <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        // released bus shows inverted junk, not the old value
        req_out <= '{1'b0, 1'b0, ~w, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ===== tb_trace_sram_access_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_trace_sram_access_port
    import tsap_pkg::*;
;
    localparam logic [31:0] ALL_M = 32'hffff_ffff;
    logic          clk_in, rst_in, run, fin, idm, rdy;
    tsap_apb_req_t apb;
    logic [31:0]   prd, cnt;
    logic [4:0]    trig;
    logic [7:0]    act, tid;
    tsap_cap_wr_t  cap;
    logic [63:0]   q[$], nx, pay_m[16];
    logic [7:0]    hdr_m[16];
    int            n_fail = 0, checks = 0, cyc = 0;
    tsap_top #(.ADDR_W(4), .PAY_W(64), .STATES_N(5), .ID_W(8)) i_dut (
        .clk_in(clk_in), .rst_in(rst_in), .apb_in(apb), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(), .run_out(run), .cap_in(cap),
        .trig_state_in(trig), .final_state_in(fin), .counter_in(cnt),
        .action_in(act), .id_match_in(idm), .txn_id_in(tid));
    tsap_host i_host (.clk_in(clk_in), .pready_in(rdy), .req_out(apb));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t read got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d);
    endtask
    // expectation noted first; the monitor pairs it with the read
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        q.push_back({m, e & m});
        i_host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic put(input int i);
        hdr_m[i] = 8'($urandom());
        pay_m[i] = {$urandom(), $urandom()};
        wr(TSAP_OFF_WR_DATA, {24'($urandom()), hdr_m[i]});
        wr(TSAP_OFF_WR_DATA, pay_m[i][31:0]);
        wr(TSAP_OFF_WR_DATA, pay_m[i][63:32]);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // read monitor, prdata only valid in the access phase
    always @(posedge clk_in) begin
        if (apb.psel && apb.penable && !apb.pwrite && q.size() > 0) begin
            nx = q.pop_front();
            check(prd & nx[63:32], nx[31:0]);
        end
    end
    // hang guard, about ten times the expected length
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        {rst_in, trig, fin, cnt, act, idm, tid} = {1'b1, 5'h01, 50'h0};
        cap = '0;
        void'($urandom(82441));
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        cnt <= $urandom();
        act <= 8'($urandom());
        rd(TSAP_OFF_STATE, ALL_M, 32'h0);
        rd(TSAP_OFF_ACTION, ALL_M, {24'h0, act});
        rd(TSAP_OFF_COUNT, ALL_M, cnt);
        // live counter moves, snapshot must keep the value from the last state register read
        cnt <= ~cnt;
        rd(TSAP_OFF_COUNT, ALL_M, cnt);
        rd(12'h0fc, ALL_M, 32'h0);
        $display("test 1 done");
        wr(TSAP_OFF_WR_ADDR, 32'h0000_000e);
        wr(12'h000, 32'h1);
        for (int i = 0; i < 18; i++) begin
            cap <= '{1'b1, 8'(i), {64'h0, $urandom(), $urandom()}};
            idm <= (i == 3);
            tid <= 8'(i + 8'h50);
            @(posedge clk_in);
        end
        cap.we <= 1'b0;
        idm <= 1'b0;
        trig <= 5'h04;
        rd(TSAP_OFF_STATE, ALL_M, 32'h0000_0004);
        fin <= 1'b1;
        @(posedge clk_in);
        fin <= 1'b0;
        trig <= 5'h10;
        rd(TSAP_OFF_STATE, ALL_M, 32'h8000_0004);
        rd(TSAP_OFF_COUNT, ALL_M, cnt);
        $display("test 2 done");
        wr(12'h000, 32'h0);
        rd(TSAP_OFF_STATE, ALL_M, 32'h0);
        rd(TSAP_OFF_TXNID, ALL_M, 32'h53);
        rd(TSAP_OFF_WR_ADDR, 32'h8000_000f, 32'h8000_0000);
        $display("test 3 done");
        for (int i = 0; i < 16; i++) put(i);
        rd(TSAP_OFF_WR_ADDR, 32'h8000_000f, 32'h8000_0000);
        wr(TSAP_OFF_WR_DATA, 32'h0000_00ff);
        wr(TSAP_OFF_WR_ADDR, 32'h0000_0005);
        put(5);
        rd(TSAP_OFF_WR_ADDR, 32'h8000_000f, 32'h0000_0006);
        $display("test 4 done");
        wr(TSAP_OFF_RD_ADDR, 32'h0000_000f);
        rd(TSAP_OFF_RD_ADDR, 32'h0000_000f, 32'h0);
        rd(TSAP_OFF_RD_DATA, ALL_M, {24'h0, hdr_m[15]});
        wr(TSAP_OFF_RD_ADDR, 32'h0000_000f);
        for (int k = 15; k < 19; k++) begin
            rd(TSAP_OFF_RD_DATA, ALL_M, {24'h0, hdr_m[k%16]});
            rd(TSAP_OFF_RD_DATA, ALL_M, pay_m[k%16][31:0]);
            rd(TSAP_OFF_RD_DATA, ALL_M, pay_m[k%16][63:32]);
        end
        rd(TSAP_OFF_RD_ADDR, 32'h0000_000f, 32'h0000_0004);
        $display("test 5 done");
        close_out();
    end
endmodule
`default_nettype wire
